/* File: sas_adc_sequencer.sv */
// Converter sequencer top: AXI4-Lite registers, run control, results and flags.
// Assumes trigger inputs and comparator output are synchronous to clock.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RULE1) Each conversion starts with four or eight converter clocks of sampling.
// (RULE2) Comparison phase takes twelve converter clocks; conversion totals sixteen to twenty.
// (RULE3) Single mode converts once per start on the selected channel.
// (RULE4) Any mode starts from the start bit or a selected hardware trigger.
// (RULE5) Single conversion end clears start bit and stores last result.
// (RULE6) Mode bit 0 selects single, 1 selects continuous.
// (RULE7) Continuous mode cycles through channels enabled in the mask.
// (RULE8) Conversion count counts down per conversion; run stops at zero.
// (RULE9) Completed continuous or accumulating run sets sequence done flag.
// (RULE10) Per-channel result register holds that channel's latest value; here written in continuous mode only, not by single conversions.
// (RULE11) Accumulate enable selects accumulating continuous mode.
// (RULE12) Accumulating mode adds each result into the accumulated register.
// (RULE13) Writing one to accumulator clear zeroes the accumulated register.
// (RULE14) Writing one to sequence reset returns channel position and count.
// (RULE15) Software enables converter before starting and disables it afterwards.
// (RULE16) Software clears flag, enables irq, resets, enables, then starts.
// (RULE17) Sequence done enable lets its flag reach the interrupt output.
// (RULE18) Each threshold comparison acts only while its enable is set.
// (RULE19) Result at or above upper threshold sets above upper flag.
// (RULE20) Result below lower threshold sets below lower flag.
// (RULE21) Result in lower-inclusive, upper-exclusive window sets in window flag.
// (RULE22) Writing one to a clear bit clears that flag; zero does nothing.
// (RULE23) Sample select value zero gives four sampling periods.
// (RULE24) Three-bit channel select picks one of eight; 111 is calibration.
// (RULE25) Masked status is raw AND enable; interrupt is their OR.
// (RULE26) Drives sample control and trial code, one decision per clock, MSB first.
module sas_adc_sequencer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Hardware triggers
  input  wire logic [9:0]  trigIn,
  // Analog core
  output logic [2:0]       analogChannel,
  output logic             sampleCtl,
  output logic [11:0]      trialCode,
  input  wire logic        cmpIn,
  // Interrupt
  output logic             irq
);
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} sas_seq_t;

  // Control registers
  logic [31:0] ctrl0_r;
  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [11:0] upper_r;
  logic [11:0] lower_r;
  logic [3:0]  irqEn_r;
  logic [3:0]  raw_r;
  logic        start_r;
  // Results
  logic [11:0] chRes_r [8];
  logic [11:0] lastRes_r;
  logic [sas_pkg::ACC_W-1:0] acc_r;
  // Sequencer
  sas_seq_t    seq_r;
  logic [2:0]  chan_r;
  logic [2:0]  pos_r;
  logic [7:0]  rem_r;
  logic        launch_r;
  logic [6:0]  div_r;

  // Bus write channel
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  wire wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire [31:0] wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire [31:0] wBits = wData_r & wMask;
  wire wrC0  = wrFire && awAddr_r == sas_pkg::OFS_CTRL0;
  wire wrC1  = wrFire && awAddr_r == sas_pkg::OFS_CTRL1;
  wire wrC2  = wrFire && awAddr_r == sas_pkg::OFS_CTRL2;
  wire wrUp  = wrFire && awAddr_r == sas_pkg::OFS_UPPER;
  wire wrLo  = wrFire && awAddr_r == sas_pkg::OFS_LOWER;
  wire wrIen = wrFire && awAddr_r == sas_pkg::OFS_IRQEN;
  wire wrClr = wrFire && awAddr_r == sas_pkg::OFS_IRQCLR;
  wire wrOk  = wrC0 || wrC1 || wrC2 || wrUp || wrLo || wrIen || wrClr;

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready = !wHeld_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sas_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Field views
  wire        enBit   = ctrl0_r[sas_pkg::B_EN];
  wire [2:0]  clkSel  = ctrl0_r[sas_pkg::B_CLKSEL +: 3];
  wire [2:0]  chSel   = ctrl0_r[sas_pkg::B_CHSEL +: 3];
  wire        samLong = ctrl0_r[sas_pkg::B_SAMLONG];
  wire [9:0]  trigSel = ctrl1_r[sas_pkg::B_TRIG +: 10];
  // (RULE6) mode bit: 0 single, 1 continuous
  wire        contMode = ctrl1_r[sas_pkg::B_MODE];
  wire        accEn   = ctrl1_r[sas_pkg::B_ACCEN];
  wire [7:0]  chEn    = ctrl2_r[sas_pkg::B_CHEN +: 8];
  wire [7:0]  cntCfg  = ctrl2_r[sas_pkg::B_CNT +: 8];
  wire seqRst = wrC0 && wBits[sas_pkg::B_SEQRST];
  wire accClr = wrC1 && wBits[sas_pkg::B_ACCCLR];
  wire swStart = wrC0 && wStrb_r[0] && wData_r[sas_pkg::B_START];
  wire swStop  = wrC0 && wStrb_r[0] && !wData_r[sas_pkg::B_START];
  // (RULE4) software bit or selected trigger
  wire hwStart = |(trigIn & trigSel);

  // Converter clock divider; power of two set by the clock select field
  wire [6:0] divMax = 7'(({7'h0, 1'b1} << clkSel) - 8'h01);
  wire convTick = (div_r >= divMax);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) div_r <= 7'h00;
    else div_r <= (convTick || !enBit) ? 7'h00 : div_r + 7'h01;
  end

  // Engine and comparator
  logic        engBusy;
  logic        engDone;
  logic [11:0] engRes;
  logic        aboveHit;
  logic        belowHit;
  logic        windowHit;
  sas_sar_engine u_engine (
    .clock      (clock),
    .rst_b      (rst_b),
    .tick       (convTick),
    .start      (launch_r),
    .sampleLong (samLong),
    .cmpIn      (cmpIn),
    .sampleCtl  (sampleCtl),
    .trialCode  (trialCode),
    .busy       (engBusy),
    .done       (engDone),
    .result     (engRes)
  );
  // (RULE18) each check gated by its own enable
  sas_threshold_cmp #(.W(sas_pkg::RES_W)) u_cmp (
    .value     (engRes),
    .upper     (upper_r),
    .lower     (lower_r),
    .upEn      (ctrl1_r[sas_pkg::B_UPEN]),
    .loEn      (ctrl1_r[sas_pkg::B_LOEN]),
    .winEn     (ctrl1_r[sas_pkg::B_WINEN]),
    .aboveHit  (aboveHit),
    .belowHit  (belowHit),
    .windowHit (windowHit)
  );

  // Next enabled channel after p, wrapping
  function automatic logic [2:0] nextCh(input logic [7:0] m, input logic [2:0] p);
    logic [2:0] c;
    logic       found;
    nextCh = p;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      c = p + 3'(i);
      if (!found && m[c]) begin
        nextCh = c;
        found = 1'b1;
      end
    end
  endfunction

  // Sequencer decisions
  wire go = (seq_r == SEQ_IDLE) && start_r && enBit && !seqRst;
  wire emptyRun = contMode && (cntCfg == 8'h00 || chEn == 8'h00);
  wire convEnd = (seq_r == SEQ_CONV) && engDone;
  wire lastConv = !contMode || (rem_r == 8'h01);
  wire runEnd = (convEnd && lastConv) || (go && emptyRun);
  wire seqDoneSet = contMode && runEnd;
  wire [2:0] firstCh = contMode ? nextCh(chEn, pos_r) : chSel;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seq_r <= SEQ_IDLE;
      chan_r <= 3'h0;
      pos_r <= sas_pkg::POS_RST;
      rem_r <= 8'h00;
      launch_r <= 1'b0;
    end else begin
      launch_r <= 1'b0;
      if (seqRst || !enBit) begin
        // (RULE14) position and count back to start
        seq_r <= SEQ_IDLE;
        pos_r <= sas_pkg::POS_RST;
        rem_r <= 8'h00;
      end else if (go && !emptyRun) begin
        // (RULE3) (RULE24) single channel from select field
        seq_r <= SEQ_CONV;
        chan_r <= firstCh;
        rem_r <= cntCfg;
        launch_r <= 1'b1;
      end else if (convEnd) begin
        // (RULE8) count down, stop at zero
        rem_r <= contMode ? rem_r - 8'h01 : rem_r;
        pos_r <= chan_r;
        if (lastConv) begin
          seq_r <= SEQ_IDLE;
        end else begin
          // (RULE7) cycle through enabled mask
          chan_r <= nextCh(chEn, chan_r);
          launch_r <= 1'b1;
        end
      end
    end
  end
  assign analogChannel = chan_r;

  // Start bit: a new request wins over the end-of-run clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) start_r <= 1'b0;
    else if (swStart || hwStart) start_r <= 1'b1;
    // (RULE5) cleared by hardware at run end
    else if (runEnd || swStop) start_r <= 1'b0;
  end

  // Configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_r <= 32'h0000_0000;
      ctrl1_r <= 16'h0000;
      ctrl2_r <= 16'h0000;
      upper_r <= sas_pkg::UPPER_RST;
      lower_r <= 12'h000;
      irqEn_r <= 4'h0;
    end else begin
      // Strobe-only bits are never stored
      if (wrC0) ctrl0_r <= 32'h0000_0f71 & ((ctrl0_r & ~wMask) | wBits);
      if (wrC1) ctrl1_r <= 16'hefff & ((ctrl1_r & ~wMask[15:0]) | wBits[15:0]);
      if (wrC2) ctrl2_r <= (ctrl2_r & ~wMask[15:0]) | wBits[15:0];
      if (wrUp) upper_r <= (upper_r & ~wMask[11:0]) | wBits[11:0];
      if (wrLo) lower_r <= (lower_r & ~wMask[11:0]) | wBits[11:0];
      if (wrIen) irqEn_r <= (irqEn_r & ~wMask[3:0]) | wBits[3:0];
    end
  end

  // Results and accumulator
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastRes_r <= 12'h000;
      acc_r <= '0;
      for (int i = 0; i < 8; i++) chRes_r[i] <= 12'h000;
    end else begin
      if (convEnd) begin
        lastRes_r <= engRes;
        // (RULE10) newest continuous-mode value per channel
        if (contMode) chRes_r[chan_r] <= engRes;
      end
      // (RULE13) clear; (RULE12) (RULE11) add each result
      if (accClr) acc_r <= '0;
      else if (convEnd && contMode && accEn) acc_r <= acc_r + sas_pkg::ACC_W'(engRes);
    end
  end

  // Raw flags: a set in the clearing cycle wins
  wire [3:0] flagSet = {belowHit && convEnd, aboveHit && convEnd,
                        windowHit && convEnd, seqDoneSet};
  wire [3:0] flagClr = wrClr ? wBits[3:0] : 4'h0;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) raw_r <= 4'h0;
    // (RULE9) (RULE22) set, or clear by writing one
    else raw_r <= (raw_r & ~flagClr) | flagSet;
  end
  // (RULE25) (RULE17) mask then OR
  wire [3:0] masked = raw_r & irqEn_r;
  assign irq = |masked;

  // Bus read channel
  wire [7:0] rAddr = s_axi_araddr;
  wire rdCh = rAddr >= sas_pkg::OFS_CHRES0 && rAddr <= sas_pkg::OFS_CHRES7 && rAddr[1:0] == 2'h0;
  wire [7:0] chOfs = rAddr - sas_pkg::OFS_CHRES0;
  logic [31:0] rdVal;
  logic        rdOk;
  always_comb begin
    rdOk = 1'b1;
    rdVal = 32'h0000_0000;
    if (rdCh) rdVal = {20'h0, chRes_r[chOfs[4:2]]};
    else begin
      unique case (rAddr)
        sas_pkg::OFS_CTRL0:   rdVal = ctrl0_r | {30'h0, start_r, 1'b0};
        sas_pkg::OFS_CTRL1:   rdVal = {16'h0, ctrl1_r};
        sas_pkg::OFS_CTRL2:   rdVal = {16'h0, ctrl2_r};
        sas_pkg::OFS_LASTRES: rdVal = {20'h0, lastRes_r};
        sas_pkg::OFS_ACCRES:  rdVal = {12'h0, acc_r};
        sas_pkg::OFS_UPPER:   rdVal = {20'h0, upper_r};
        sas_pkg::OFS_LOWER:   rdVal = {20'h0, lower_r};
        sas_pkg::OFS_IRQEN:   rdVal = {28'h0, irqEn_r};
        sas_pkg::OFS_IRQCLR:  rdVal = 32'h0000_0000;
        sas_pkg::OFS_RAWIRQ:  rdVal = {28'h0, raw_r};
        sas_pkg::OFS_MSKIRQ:  rdVal = {28'h0, masked};
        default:              rdOk = 1'b0;
      endcase
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sas_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdVal;
      s_axi_rresp <= rdOk ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence singleEnd;
    convEnd && !contMode;
  endsequence
  chk_single_clear: assert property (@(posedge clock) disable iff (!rst_b) // RULE5
    singleEnd ##0 !(swStart || hwStart) |=> !start_r && lastRes_r == $past(engRes))
    else $error("single conversion end did not clear start");
  chk_single_once: assert property (@(posedge clock) disable iff (!rst_b) // RULE3
    singleEnd |=> seq_r == SEQ_IDLE)
    else $error("single mode kept converting");
  chk_done_flag: assert property (@(posedge clock) disable iff (!rst_b) // RULE9
    convEnd && contMode && rem_r == 8'h01 |=> raw_r[sas_pkg::F_DONE])
    else $error("sequence done flag not set");
  chk_count_down: assert property (@(posedge clock) disable iff (!rst_b) // RULE8
    convEnd && contMode && rem_r > 8'h01 && enBit && !seqRst
      |=> rem_r == $past(rem_r) - 8'h01 ##0 launch_r)
    else $error("count not decremented");
  chk_chan_result: assert property (@(posedge clock) disable iff (!rst_b) // RULE10
    convEnd && contMode |=> chRes_r[$past(chan_r)] == $past(engRes))
    else $error("channel result not stored");
  chk_acc_clear: assert property (@(posedge clock) disable iff (!rst_b) // RULE13
    accClr |=> acc_r == '0)
    else $error("accumulator not cleared");
  chk_seq_reset: assert property (@(posedge clock) disable iff (!rst_b) // RULE14
    seqRst |=> seq_r == SEQ_IDLE && pos_r == sas_pkg::POS_RST && rem_r == 8'h00)
    else $error("sequence reset ineffective");
  chk_above_flag: assert property (@(posedge clock) disable iff (!rst_b) // RULE19
    convEnd && ctrl1_r[sas_pkg::B_UPEN] && engRes >= upper_r |=> raw_r[sas_pkg::F_UP])
    else $error("above upper flag missing");
  chk_flag_clear: assert property (@(posedge clock) disable iff (!rst_b) // RULE22
    wrClr && wBits[sas_pkg::F_WIN] && !flagSet[sas_pkg::F_WIN] |=> !raw_r[sas_pkg::F_WIN])
    else $error("window flag not cleared");
  chk_irq_masked: assert property (@(posedge clock) disable iff (!rst_b) // RULE17
    $rose(raw_r[sas_pkg::F_DONE]) && irqEn_r[sas_pkg::F_DONE] |-> irq)
    else $error("done flag did not raise interrupt");
endmodule
`default_nettype wire

/* File: sas_core_model.sv */
// Analog comparator core model: one fixed level per channel.
// Assumes the sequencer holds the trial code steady per tick.
`timescale 1ns/1ps
`default_nettype none
module sas_core_model (
  // Control from sequencer
  input  wire logic [2:0]  analogChannel,
  input  wire logic        sampleCtl,
  input  wire logic [11:0] trialCode,
  // Decision
  output logic             cmpIn
);
  logic [11:0] level;
  assign level = {1'b0, analogChannel, 8'h10};
  // decision per trial
  // Output is meaningless while sampling, so it reads low
  assign cmpIn = !sampleCtl && (level >= trialCode);
endmodule
`default_nettype wire

/* File: sas_pkg.sv */
// Constants shared by the converter sequencer: register map, fields, resets, timing.
// Assumes a 32-bit AXI4-Lite register bus and a 12-bit comparator core.
`default_nettype none
package sas_pkg;
  localparam int RES_W = 12;
  localparam int ACC_W = 20;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_CTRL2   = 8'h08;
  localparam logic [7:0] OFS_CHRES0  = 8'h0c;
  localparam logic [7:0] OFS_CHRES7  = 8'h28;
  localparam logic [7:0] OFS_LASTRES = 8'h2c;
  localparam logic [7:0] OFS_ACCRES  = 8'h30;
  localparam logic [7:0] OFS_UPPER   = 8'h34;
  localparam logic [7:0] OFS_LOWER   = 8'h38;
  localparam logic [7:0] OFS_IRQEN   = 8'h44;
  localparam logic [7:0] OFS_IRQCLR  = 8'h48;
  localparam logic [7:0] OFS_RAWIRQ  = 8'h4c;
  localparam logic [7:0] OFS_MSKIRQ  = 8'h50;
  // Control 0 fields
  localparam int B_EN = 0;
  localparam int B_START = 1;
  localparam int B_CLKSEL = 4;
  localparam int B_CHSEL = 8;
  localparam int B_SAMLONG = 11;
  localparam int B_SEQRST = 15;
  // Control 1 fields
  localparam int B_TRIG = 0;
  localparam int B_MODE = 10;
  localparam int B_ACCEN = 11;
  localparam int B_ACCCLR = 12;
  localparam int B_UPEN = 13;
  localparam int B_LOEN = 14;
  localparam int B_WINEN = 15;
  // Control 2 fields
  localparam int B_CHEN = 0;
  localparam int B_CNT = 8;
  // Flag bits in enable, clear, raw and masked registers
  localparam int F_DONE = 0;
  localparam int F_WIN = 1;
  localparam int F_UP = 2;
  localparam int F_LO = 3;
  // Reset values
  localparam logic [11:0] UPPER_RST = 12'hfff;
  localparam logic [2:0]  POS_RST   = 3'h7;
  // Converter clock counts and bus response codes
  localparam logic [3:0] SAMPLE_SHORT = 4'h4;
  localparam logic [3:0] SAMPLE_LONG  = 4'h8;
  localparam logic [3:0] COMPARE_CLKS = 4'hc;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: sas_sar_engine.sv */
// Sampling and successive approximation engine for one conversion.
// Assumes tick is a one-cycle converter clock enable and cmpIn is valid per tick.
`timescale 1ns/1ps
`default_nettype none
module sas_sar_engine (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Control
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        sampleLong,
  // Analog core
  input  wire logic        cmpIn,
  output logic             sampleCtl,
  output logic [11:0]      trialCode,
  // Result
  output logic             busy,
  output logic             done,
  output logic [11:0]      result
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_SAMPLE, ENG_COMPARE} sas_eng_t;
  sas_eng_t    state_r;
  logic [3:0]  cnt_r;
  logic [3:0]  bit_r;
  logic [11:0] code_r;
  logic [11:0] kept;
  // (RULE23) select 0 gives four periods
  wire  [3:0]  smpLen = sampleLong ? sas_pkg::SAMPLE_LONG : sas_pkg::SAMPLE_SHORT;
  // Comparator high keeps the trial bit
  assign kept = cmpIn ? code_r : (code_r & ~(12'h001 << bit_r));
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ENG_IDLE;
      cnt_r <= 4'h0;
      bit_r <= 4'h0;
      code_r <= 12'h000;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      unique case (state_r)
        ENG_IDLE: if (start) begin
          // (RULE1) sample length select
          state_r <= ENG_SAMPLE;
          cnt_r <= smpLen - 4'h1;
        end
        ENG_SAMPLE: if (tick) begin
          if (cnt_r == 4'h0) begin
            state_r <= ENG_COMPARE;
            bit_r <= 4'hb;
            code_r <= 12'h800;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        // (RULE2) twelve ticks, bit 11 down to 0
        ENG_COMPARE: if (tick) begin
          // (RULE26) one decision per tick, MSB first
          if (bit_r == 4'h0) begin
            state_r <= ENG_IDLE;
            result <= kept;
            done <= 1'b1;
          end else begin
            code_r <= kept | (12'h001 << (bit_r - 4'h1));
            bit_r <= bit_r - 4'h1;
          end
        end
      endcase
    end
  end
  assign sampleCtl = (state_r == ENG_SAMPLE);
  assign trialCode = code_r;
  assign busy = (state_r != ENG_IDLE);

  // Tick counters per phase, for checking only
  logic [3:0] smpTicks;
  logic [3:0] cmpTicks;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      smpTicks <= 4'h0;
      cmpTicks <= 4'h0;
    end else begin
      smpTicks <= (state_r == ENG_SAMPLE) ? smpTicks + {3'h0, tick} : 4'h0;
      cmpTicks <= (state_r == ENG_COMPARE) ? cmpTicks + {3'h0, tick} : 4'h0;
    end
  end
  chk_sample_length: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
    (state_r == ENG_SAMPLE && tick && cnt_r == 4'h0) |-> (smpTicks + 4'h1 == smpLen))
    else $error("sampling phase length wrong");
  chk_compare_twelve: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
    $rose(done) |-> ($past(cmpTicks) + 4'h1 == sas_pkg::COMPARE_CLKS))
    else $error("comparison phase not twelve clocks");
endmodule
`default_nettype wire

/* File: sas_threshold_cmp.sv */
// Threshold comparison of one result against upper and lower limits.
// Assumes the caller samples the hits on the conversion done pulse.
`timescale 1ns/1ps
`default_nettype none
module sas_threshold_cmp #(
  parameter int W = 12
) (
  // Operands
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] upper,
  input  wire logic [W-1:0] lower,
  // Enables
  input  wire logic         upEn,
  input  wire logic         loEn,
  input  wire logic         winEn,
  // Hits
  output logic              aboveHit,
  output logic              belowHit,
  output logic              windowHit
);
  // (RULE19) range upper threshold up to full scale
  assign aboveHit = upEn && (value >= upper);
  // (RULE20) range zero up to below lower threshold
  assign belowHit = loEn && (value < lower);
  // (RULE21) range lower inclusive to upper exclusive
  assign windowHit = winEn && (value >= lower) && (value < upper);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench: AXI4-Lite register tests of the converter sequencer.
// Assumes clock divider 0, except divider 1 in single test 1, and the core model levels.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [9:0] trigIn = 0;
  logic awready, wready, bvalid, arready, rvalid, sampleCtl, cmpIn, irq;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] analogChannel, chs[3] = '{3'h7, 3'h3, 3'h0};
  logic [11:0] trialCode;
  logic [31:0] flg[3] = '{32'h4, 32'h2, 32'h8};
  int bad_count = 0, compares = 0, cycles = 0;
  sas_adc_sequencer dut (.clock(clock), .rst_b(rst_b), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .trigIn(trigIn), .analogChannel(analogChannel),
    .sampleCtl(sampleCtl), .trialCode(trialCode), .cmpIn(cmpIn), .irq(irq));
  sas_core_model core (.analogChannel(analogChannel), .sampleCtl(sampleCtl),
    .trialCode(trialCode), .cmpIn(cmpIn));
  always #25 clock = ~clock;
  function automatic logic [31:0] v(input logic [2:0] c);
    return {21'h0, c, 8'h10};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= x; bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    arvalid <= 1; araddr <= a; rready <= 1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 0;
  endtask
  task automatic waitbit(input logic [7:0] a, input int b, input logic x);
    do rd(a); while (d[b] !== x);
  endtask
  task report_and_stop;
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the expected few hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1;
    rd(sas_pkg::OFS_UPPER); chk("upper reset", 32'hfff, d);
    rd(8'h3c); chk("unmapped resp", 32'h2, {30'h0, resp});
    wr(8'h3c, 32'h0); chk("unmapped wr", 32'h2, {30'h0, resp});
    wr(sas_pkg::OFS_UPPER, 32'h400); wr(sas_pkg::OFS_LOWER, 32'h200);
    wr(sas_pkg::OFS_CTRL1, 32'he001); chk("write resp", 32'h0, {30'h0, resp});
    for (int i = 0; i < 3; i++) begin
      wr(sas_pkg::OFS_IRQCLR, 32'hf);
      wr(sas_pkg::OFS_CTRL0, 32'h1 | ((i != 2) ? 32'h2 : 32'h0) | (32'(chs[i]) << 8)
        | (32'(i % 2) * 32'h810));
      if (i == 2) begin
        @(posedge clock); trigIn <= 10'h1;
        @(posedge clock); trigIn <= 10'h0;
      end
      waitbit(sas_pkg::OFS_CTRL0, 1, 1'b0);
      rd(sas_pkg::OFS_LASTRES); chk("last result", v(chs[i]), d);
      rd(sas_pkg::OFS_RAWIRQ); chk("raw flags", flg[i], d);
      $display("Test single %0d done", i);
    end
    wr(sas_pkg::OFS_IRQCLR, 32'h0); rd(sas_pkg::OFS_RAWIRQ); chk("raw kept", 32'h8, d);
    wr(sas_pkg::OFS_IRQEN, 32'h8); rd(sas_pkg::OFS_MSKIRQ); chk("masked", 32'h8, d);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(sas_pkg::OFS_IRQCLR, 32'h8); chk("irq clear", 32'h0, {31'h0, irq});
    wr(sas_pkg::OFS_CTRL1, 32'h1c00); wr(sas_pkg::OFS_CTRL2, 32'h0423);
    wr(sas_pkg::OFS_IRQCLR, 32'h1); wr(sas_pkg::OFS_IRQEN, 32'h1);
    wr(sas_pkg::OFS_CTRL0, 32'h8001); wr(sas_pkg::OFS_CTRL0, 32'h1);
    wr(sas_pkg::OFS_CTRL0, 32'h3); waitbit(sas_pkg::OFS_RAWIRQ, 0, 1'b1);
    chk("flags gated", 32'h1, d);
    rd(sas_pkg::OFS_ACCRES); chk("acc sum", 32'h640, d);
    rd(sas_pkg::OFS_CHRES0); chk("ch0 result", v(3'h0), d);
    rd(8'h20); chk("ch5 result", v(3'h5), d);
    rd(8'h18); chk("ch3 untouched", 32'h0, d);
    wr(sas_pkg::OFS_CTRL1, 32'h1c00); rd(sas_pkg::OFS_ACCRES); chk("acc clear", 32'h0, d);
    chk("irq done", 32'h1, {31'h0, irq});
    wr(sas_pkg::OFS_CTRL0, 32'h0);
    $display("Test continuous done");
    report_and_stop();
  end
endmodule
`default_nettype wire
